// ### prc_consts.vh
// Purpose: shared constants of the pump run/alarm panel supervisor
// Assumes: 250 MHz system clock
// Notes: register indices sit on the strobed register port
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH

// clock and times in their own units
`define PRC_CLK_HZ 250000000
`define PRC_RESET_HOLD_US 5000
`define PRC_UV_RIDE_MS 1000
`define PRC_BLINK_MS 250
`define PRC_TMR_W 28

// register indices
`define PRC_A_STATUS 2'h0
`define PRC_A_RETRY 2'h1
`define PRC_A_MAXSPD 2'h2
`define PRC_A_RATED 2'h3

// reset values
`define PRC_RETRY_RST 4'h3
`define PRC_MAXSPD_RST 16'h1770
`define PRC_RATED_RST 16'h1194
`define PRC_LOCAL_RST 1'b1

// alarm bit positions
`define PRC_AL_OC 0
`define PRC_AL_OV 1
`define PRC_AL_UV 2
`define PRC_AL_CP 3
`define PRC_AL_SFO 4
`define PRC_AL_OH 5
`define PRC_AL_OL 6
`define PRC_AL_EF 7
`define PRC_NAL 8

// screen items
`define PRC_SCR_SPEED 2'h0
`define PRC_SCR_MODE 2'h1
`define PRC_SCR_RETRY 2'h2

`endif

// ### prc_panel_alarm.v
// Purpose: run/stop, alarm latch and panel logic of a pump drive
// Assumes: contacts, buttons and fault flags are asynchronous levels
// Notes: contact outputs are 1 = closed; seven-segment bit 0 = seg a
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "prc_consts.vh"

// Behaviour
// - alarm-reset contact acts only when held closed longer than 5 ms.
// - speed-mode closed: speed proportional to analog input, max at 10 V.
// - run status contact closed while running; alarm contact open on alarm.
// - panel run button starts the pump only in local mode.
// - panel stop button stops the pump in either mode.
// - escape button returns screen to the previous menu.
// - panel reset button acts as a fault reset.
// - local/remote button toggles the control mode.
// - run lamp on running, flashing decelerating, off stopped.
// - mode lamp lit in local mode, off in remote.
// - alarm lamp on for alarm, flashing for minor failure, else off.
// - speed lamp lit only while screen shows rotation speed.
// - fixed glyph table on seven-segment screen; X and Z blank.
// - any alarm stops pump, lights alarm lamp, shows its code.
// - no restart until the alarm's recovery condition is met.
// - alarms latch; clear needs cause gone plus reset, step-out reset only; the code keeps step-out latched while step_out is high.
// - over-voltage retries blinking; persisting after retries latches alarm.
// - under-voltage blinks; clearing within 1 s leaves no alarm.
// - remote mode follows the run contact: closed runs, open stops.
// - start commands from either source are refused while alarmed.
// - mode changes are ignored while the run lamp is on.
// - speed mode only in remote; dropping it returns rated speed.
module prc_panel_alarm #(
    parameter ADC_W = 10,
    parameter [`PRC_TMR_W-1:0] RESET_HOLD_CYC =
        `PRC_RESET_HOLD_US * (`PRC_CLK_HZ / 1000000),
    parameter [`PRC_TMR_W-1:0] UV_RIDE_CYC =
        `PRC_UV_RIDE_MS * (`PRC_CLK_HZ / 1000),
    parameter [`PRC_TMR_W-1:0] BLINK_CYC =
        `PRC_BLINK_MS * (`PRC_CLK_HZ / 1000)
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // remote contacts
    input wire run_contact,
    input wire alarm_reset_contact,
    input wire speed_mode_contact,
    input wire [ADC_W-1:0] speed_voltage,
    output reg run_status_contact,
    output reg alarm_status_contact,
    // panel buttons
    input wire btn_run,
    input wire btn_stop,
    input wire btn_up,
    input wire btn_down,
    input wire btn_esc,
    input wire btn_reset,
    input wire local_remote_select,
    // inverter fault causes and motion feedback
    input wire overcurrent,
    input wire overvoltage_condition,
    input wire undervoltage_condition,
    input wire control_power_fault,
    input wire step_out,
    input wire inverter_overheat,
    input wire overload,
    input wire motor_overheat,
    input wire motor_stopped,
    // drive command
    output reg drive_enable,
    output reg [15:0] speed_cmd,
    // lamps and screen
    output reg run_lamp,
    output reg mode_lamp,
    output reg alarm_lamp,
    output reg speed_display_lamp,
    output reg drive_ready_lamp,
    output reg reverse_rotation_lamp,
    output reg [6:0] seg_d0,
    output reg [6:0] seg_d1,
    output reg [6:0] seg_d2,
    // register port
    input wire [1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata
);

    localparam NS = 19;
    localparam I_RUN = 0, I_ARST = 1, I_SPM = 2, I_BRUN = 3, I_BSTOP = 4;
    localparam I_UP = 5, I_DN = 6, I_ESC = 7, I_BRST = 8, I_LR = 9;
    localparam I_AL = 10, I_MSTOP = 18;
    localparam [2:0] ST_STOP = 3'b001, ST_RUN = 3'b010, ST_DEC = 3'b100;
    localparam [5:0] CH_BLANK = 6'h24;

    reg rst_s1, rst_s2;
    wire rst_n = rst_s2;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // three-stage synchronisers; a change counts once stages 2 and 3 agree
    wire [NS-1:0] raw_in = {motor_stopped, motor_overheat, overload,
        inverter_overheat, step_out, control_power_fault,
        undervoltage_condition, overvoltage_condition, overcurrent,
        local_remote_select, btn_reset, btn_esc, btn_down, btn_up,
        btn_stop, btn_run, speed_mode_contact, alarm_reset_contact,
        run_contact};
    reg [NS-1:0] sy1, sy2, sy3, stab, stab_d;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sy1 <= {NS{1'b0}};
            sy2 <= {NS{1'b0}};
            sy3 <= {NS{1'b0}};
            stab <= {NS{1'b0}};
            stab_d <= {NS{1'b0}};
        end else begin
            sy1 <= raw_in;
            sy2 <= sy1;
            sy3 <= sy2;
            stab <= ((sy2 ^ sy3) & stab) | (~(sy2 ^ sy3) & sy3);
            stab_d <= stab;
        end
    end
    wire [NS-1:0] rise = stab & ~stab_d;
    wire [`PRC_NAL-1:0] cause = stab[I_AL+`PRC_NAL-1:I_AL];

    // common blink enable shared by every flashing lamp and code
    reg [`PRC_TMR_W-1:0] blink_cnt;
    reg blink;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt <= {`PRC_TMR_W{1'b0}};
            blink <= 1'b0;
        end else if (blink_cnt == BLINK_CYC - 1'b1) begin
            blink_cnt <= {`PRC_TMR_W{1'b0}};
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // reset hold timer: one event per closure, only after the hold time
    reg [`PRC_TMR_W-1:0] hold_cnt;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            hold_cnt <= {`PRC_TMR_W{1'b0}};
        else if (!stab[I_ARST])
            hold_cnt <= {`PRC_TMR_W{1'b0}};
        else if (hold_cnt <= RESET_HOLD_CYC)
            hold_cnt <= hold_cnt + 1'b1;
    end
    wire hold_fire = stab[I_ARST] && hold_cnt == RESET_HOLD_CYC;
    wire reset_ev = hold_fire | rise[I_BRST];

    // registers written by software
    reg [3:0] retry_limit;
    reg [15:0] max_speed, rated_speed;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            retry_limit <= `PRC_RETRY_RST;
            max_speed <= `PRC_MAXSPD_RST;
            rated_speed <= `PRC_RATED_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `PRC_A_RETRY: retry_limit <= reg_wdata[3:0];
                `PRC_A_MAXSPD: max_speed <= reg_wdata;
                `PRC_A_RATED: rated_speed <= reg_wdata;
                default: ;
            endcase
        end
    end

    // over-voltage retries and under-voltage ride-through
    reg [3:0] retry_cnt;
    reg [`PRC_TMR_W-1:0] uv_cnt;
    reg [`PRC_NAL-1:0] alarm;
    wire ov_raw = cause[`PRC_AL_OV];
    wire uv_raw = cause[`PRC_AL_UV];
    wire ov_exhaust = rise[I_AL+`PRC_AL_OV] && retry_cnt >= retry_limit;
    wire uv_expire = uv_raw && uv_cnt == UV_RIDE_CYC - 1'b1;
    wire minor_ov = ov_raw & ~alarm[`PRC_AL_OV];
    wire minor_uv = uv_raw & ~alarm[`PRC_AL_UV];
    wire minor = minor_ov | minor_uv;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt <= 4'h0;
            uv_cnt <= {`PRC_TMR_W{1'b0}};
        end else begin
            if (reset_ev && !ov_raw)
                retry_cnt <= 4'h0;
            else if (rise[I_AL+`PRC_AL_OV] && retry_cnt < retry_limit)
                retry_cnt <= retry_cnt + 1'b1;
            if (!uv_raw || uv_expire)
                uv_cnt <= {`PRC_TMR_W{1'b0}};
            else
                uv_cnt <= uv_cnt + 1'b1;
        end
    end

    // alarm latch; a new cause wins over a reset in the same cycle
    reg [`PRC_NAL-1:0] al_set, al_clr;
    always @* begin
        al_set = cause;
        al_set[`PRC_AL_OV] = ov_exhaust;
        al_set[`PRC_AL_UV] = uv_expire;
        al_clr = {`PRC_NAL{reset_ev}} & ~cause;
        al_clr[`PRC_AL_SFO] = reset_ev;
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            alarm <= {`PRC_NAL{1'b0}};
        else
            alarm <= al_set | (alarm & ~al_clr);
    end
    wire any_alarm = |alarm;

    // control mode and run state machine
    reg local_mode;
    reg [2:0] state, next_state;
    wire run_c = stab[I_RUN];
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            local_mode <= `PRC_LOCAL_RST;
        else if (rise[I_LR] && state == ST_STOP)
            local_mode <= ~local_mode;
    end
    wire start_req = ~any_alarm &
        ((local_mode & rise[I_BRUN]) | (~local_mode & run_c));
    wire stop_req = rise[I_BSTOP] | (~local_mode & ~run_c)
        | any_alarm;
    always @* begin
        next_state = state;
        case (state)
            ST_STOP: if (start_req) next_state = ST_RUN;
            ST_RUN: if (stop_req) next_state = ST_DEC;
            ST_DEC: if (stab[I_MSTOP]) next_state = ST_STOP;
            default: next_state = ST_STOP;
        endcase
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            state <= ST_STOP;
        else
            state <= next_state;
    end

    // speed command
    wire speed_mode = ~local_mode & stab[I_SPM];
    wire [ADC_W+15:0] prod = speed_voltage * max_speed;
    reg [15:0] next_speed;
    always @* begin
        if (state != ST_RUN)
            next_speed = 16'h0000;
        else if (speed_mode)
            next_speed = prod[ADC_W+15:ADC_W];
        else
            next_speed = rated_speed;
    end

    // screen menu: item 0 is the top status screen
    reg [1:0] item;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            item <= `PRC_SCR_SPEED;
        else if (|(al_set & ~alarm))
            item <= `PRC_SCR_SPEED;
        else if (rise[I_ESC])
            item <= `PRC_SCR_SPEED;
        else if (rise[I_UP])
            item <= (item == `PRC_SCR_RETRY) ? `PRC_SCR_MODE : item + 1'b1;
        else if (rise[I_DN])
            item <= (item == `PRC_SCR_RETRY || item == `PRC_SCR_SPEED) ?
                `PRC_SCR_MODE : `PRC_SCR_RETRY;
    end

    function [6:0] glyph;
        input [5:0] ch;
        begin
            case (ch)
                6'h00: glyph = 7'h3f; 6'h01: glyph = 7'h06;
                6'h02: glyph = 7'h5b; 6'h03: glyph = 7'h4f;
                6'h04: glyph = 7'h66; 6'h05: glyph = 7'h6d;
                6'h06: glyph = 7'h7d; 6'h07: glyph = 7'h07;
                6'h08: glyph = 7'h7f; 6'h09: glyph = 7'h6f;
                6'h0a: glyph = 7'h77; 6'h0b: glyph = 7'h7c;
                6'h0c: glyph = 7'h39; 6'h0d: glyph = 7'h5e;
                6'h0e: glyph = 7'h79; 6'h0f: glyph = 7'h71;
                6'h10: glyph = 7'h3d; 6'h11: glyph = 7'h76;
                6'h12: glyph = 7'h06; 6'h13: glyph = 7'h1e;
                6'h14: glyph = 7'h75; 6'h15: glyph = 7'h38;
                6'h16: glyph = 7'h37; 6'h17: glyph = 7'h54;
                6'h18: glyph = 7'h5c; 6'h19: glyph = 7'h73;
                6'h1a: glyph = 7'h67; 6'h1b: glyph = 7'h50;
                6'h1c: glyph = 7'h6d; 6'h1d: glyph = 7'h78;
                6'h1e: glyph = 7'h3e; 6'h1f: glyph = 7'h1c;
                6'h20: glyph = 7'h2a; 6'h22: glyph = 7'h6e;
                default: glyph = 7'h00; // X, Z, blank
            endcase
        end
    endfunction

    // alarm code text, three characters
    function [17:0] code_text;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: code_text = {6'h18, 6'h0c, CH_BLANK};
                4'h1: code_text = {6'h18, 6'h1f, CH_BLANK};
                4'h2: code_text = {6'h1e, 6'h1f, 6'h01};
                4'h3: code_text = {6'h1e, 6'h1f, 6'h02};
                4'h4: code_text = {6'h1c, 6'h0f, 6'h18};
                4'h5: code_text = {6'h18, 6'h11, CH_BLANK};
                4'h6: code_text = {6'h18, 6'h15, 6'h03};
                4'h7: code_text = {6'h0e, 6'h0f, 6'h04};
                default: code_text = {CH_BLANK, CH_BLANK, CH_BLANK};
            endcase
        end
    endfunction

    // lowest-numbered latched alarm wins the screen, then a pending minor fault
    reg [3:0] al_idx;
    reg show_alarm, show_blink;
    reg [17:0] text;
    integer k;
    always @* begin
        al_idx = 4'hf;
        for (k = `PRC_NAL - 1; k >= 0; k = k - 1)
            if (alarm[k])
                al_idx = k[3:0];
        show_alarm = 1'b1;
        show_blink = 1'b0;
        if (al_idx == 4'hf) begin
            show_blink = minor;
            if (minor_ov)
                al_idx = `PRC_AL_OV;
            else if (minor_uv)
                al_idx = `PRC_AL_UV;
            else
                show_alarm = 1'b0;
        end
        if (show_alarm)
            text = code_text(al_idx);
        else if (item == `PRC_SCR_MODE)
            text = local_mode ? {6'h15, 6'h18, CH_BLANK} :
                {6'h1b, 6'h0e, CH_BLANK};
        else if (item == `PRC_SCR_RETRY)
            text = {6'h1b, 6'h1d, 2'b00, retry_cnt};
        else
            text = {2'b00, next_speed[11:8], 2'b00, next_speed[7:4],
                2'b00, next_speed[3:0]};
    end
    wire seg_on = ~(show_blink & blink);

    // registered outputs
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_status_contact <= 1'b0;
            alarm_status_contact <= 1'b0;
            drive_enable <= 1'b0;
            speed_cmd <= 16'h0000;
            run_lamp <= 1'b0;
            mode_lamp <= 1'b0;
            alarm_lamp <= 1'b0;
            speed_display_lamp <= 1'b0;
            drive_ready_lamp <= 1'b0;
            reverse_rotation_lamp <= 1'b0;
            seg_d0 <= 7'h00;
            seg_d1 <= 7'h00;
            seg_d2 <= 7'h00;
        end else begin
            run_status_contact <= state == ST_RUN;
            alarm_status_contact <= ~any_alarm;
            drive_enable <= state == ST_RUN;
            speed_cmd <= next_speed;
            run_lamp <= (state == ST_RUN) |
                ((state == ST_DEC) & blink);
            mode_lamp <= local_mode;
            alarm_lamp <= any_alarm | (minor & blink);
            speed_display_lamp <= ~show_alarm &
                (item == `PRC_SCR_SPEED);
            drive_ready_lamp <= ~any_alarm;
            reverse_rotation_lamp <= 1'b0;
            seg_d2 <= seg_on ? glyph(text[17:12]) : 7'h00;
            seg_d1 <= seg_on ? glyph(text[11:6]) : 7'h00;
            seg_d0 <= seg_on ? glyph(text[5:0]) : 7'h00;
        end
    end

    // read port: data stand for one cycle after the strobe, zero otherwise
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd) begin
            case (reg_addr)
                `PRC_A_STATUS: reg_rdata <= {3'b000, minor, local_mode,
                    state, alarm};
                `PRC_A_RETRY: reg_rdata <= {8'h00, retry_cnt, retry_limit};
                `PRC_A_MAXSPD: reg_rdata <= max_speed;
                default: reg_rdata <= rated_speed;
            endcase
        end else
            reg_rdata <= 16'h0000;
    end

endmodule // prc_panel_alarm

// ### prc_panel_alarm_bench.sv
// Purpose: self-checking bench of the pump run/alarm supervisor
// Assumes: shortened hold, ride-through and blink counts
// Notes: model keeps run, mode and alarm state as integers
`timescale 1ns/100ps
module prc_panel_alarm_bench;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg [6:0] pb = 7'h0;
    reg [7:0] fault = 8'h0;
    reg motor_stopped = 1'b1;
    reg [1:0] reg_addr = 2'h0;
    reg [15:0] reg_wdata = 16'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire run_contact, alarm_reset_contact, speed_mode_contact;
    wire [9:0] speed_voltage;
    wire run_status_contact, alarm_status_contact, drive_enable;
    wire run_lamp, mode_lamp, alarm_lamp, speed_display_lamp;
    wire drive_ready_lamp, reverse_rotation_lamp;
    wire [6:0] seg_d0, seg_d1, seg_d2;
    wire [15:0] speed_cmd, reg_rdata;
    integer n_errors = 0, tests_run = 0, seed = 98;
    integer m_run = 0, m_loc = 1, m_alm = 0, j, k;
    reg [15:0] d;
    reg [9:0] v;
    always #2 mclk = ~mclk;
    prc_tool i_tool (.mclk(mclk), .run_contact(run_contact),
        .alarm_reset_contact(alarm_reset_contact),
        .speed_mode_contact(speed_mode_contact),
        .speed_voltage(speed_voltage));
    prc_panel_alarm #(.RESET_HOLD_CYC(20), .UV_RIDE_CYC(50),
        .BLINK_CYC(4)) i_dut (
        .mclk(mclk), .reset_n(reset_n), .run_contact(run_contact),
        .alarm_reset_contact(alarm_reset_contact),
        .speed_mode_contact(speed_mode_contact),
        .speed_voltage(speed_voltage),
        .run_status_contact(run_status_contact),
        .alarm_status_contact(alarm_status_contact),
        .btn_run(pb[0]), .btn_stop(pb[1]), .btn_up(pb[2]),
        .btn_down(pb[3]), .btn_esc(pb[4]), .btn_reset(pb[5]),
        .local_remote_select(pb[6]), .overcurrent(fault[0]),
        .overvoltage_condition(fault[1]),
        .undervoltage_condition(fault[2]),
        .control_power_fault(fault[3]), .step_out(fault[4]),
        .inverter_overheat(fault[5]), .overload(fault[6]),
        .motor_overheat(fault[7]), .motor_stopped(motor_stopped),
        .drive_enable(drive_enable), .speed_cmd(speed_cmd),
        .run_lamp(run_lamp), .mode_lamp(mode_lamp),
        .alarm_lamp(alarm_lamp), .speed_display_lamp(speed_display_lamp),
        .drive_ready_lamp(drive_ready_lamp),
        .reverse_rotation_lamp(reverse_rotation_lamp), .seg_d0(seg_d0),
        .seg_d1(seg_d1), .seg_d2(seg_d2), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    task wrap_up;
        begin
            $display("checks %0d errors %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task check(input [15:0] g, input [15:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
                n_errors = n_errors + 1;
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask
    // 0 speed lamp, 1 mode, 2 run contact, 3 run lamp, 4/5 alarm
    function automatic logic o(input integer s);
        logic [5:0] w;
        begin
            w = {alarm_lamp, alarm_status_contact, run_lamp,
                 run_status_contact, mode_lamp, speed_display_lamp};
            o = w[s];
        end
    endfunction
    task wt(input integer s, input logic x);
        integer i;
        begin
            i = 0;
            while (o(s) !== x && i < 100) begin
                cyc(1);
                i = i + 1;
            end
            check(o(s), x);
            if (o(s) !== x) wrap_up;
        end
    endtask
    task cmp;
        check({run_status_contact, drive_enable, alarm_status_contact,
            mode_lamp, drive_ready_lamp, reverse_rotation_lamp},
            {m_run[0], m_run[0], m_alm == 0, m_loc[0], m_alm == 0, 1'b0});
    endtask
    task wr(input [1:0] a, input [15:0] x);
        begin
            cyc(1);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= x;
            cyc(1);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [1:0] a, output [15:0] x);
        begin
            cyc(1);
            reg_rd <= 1'b1;
            reg_addr <= a;
            cyc(1);
            reg_rd <= 1'b0;
            x = reg_rdata;
        end
    endtask
    task press(input integer i);
        begin
            cyc(1);
            pb[i] <= 1'b1;
            cyc(8);
            pb[i] <= 1'b0;
            cyc(10);
        end
    endtask
    // 0 panel button, 1 long contact closure, 2 too short closure
    task clr(input integer h);
        begin
            if (h == 0) press(5);
            else i_tool.reset_pulse(h == 1 ? 30 : 10);
            cyc(10);
        end
    endtask
    task start_l;
        begin
            press(0);
            motor_stopped <= 1'b0;
            m_run = 1;
            wt(2, 1);
        end
    endtask
    initial begin
        cyc(30000);
        n_errors = n_errors + 1;
        wrap_up;
    end
    initial begin
        cyc(2);
        reset_n <= 1'b1;
        cyc(8);
        rd(0, d); check(d, 16'h0900);
        rd(1, d); check(d, 16'h0003);
        rd(2, d); check(d, 16'h1770);
        rd(3, d); check(d, 16'h1194);
        wr(0, 16'hffff); rd(0, d); check(d, 16'h0900);
        wr(1, 16'h0002); rd(1, d); check(d, 16'h0002);
        $display("test registers done");
        start_l; cmp;
        check(speed_cmd, 16'h1194); check(speed_display_lamp, 1);
        check({seg_d2, seg_d1}, 16'h036f);
        check(seg_d0, 16'h0066);
        press(2); check(speed_display_lamp, 0);
        press(4); check(speed_display_lamp, 1);
        press(1); m_run = 0; wt(2, 0);
        wt(3, 0); wt(3, 1);
        motor_stopped <= 1'b1; cyc(12); check(run_lamp, 0);
        press(6); m_loc = 0; cmp;
        press(0); cyc(10); cmp;
        i_tool.set_run(1); motor_stopped <= 1'b0; m_run = 1;
        wt(2, 1);
        v = $random(seed);
        i_tool.set_speed(1, v); cyc(12);
        check(speed_cmd, (v * 6000) >> 10);
        i_tool.set_speed(0, v); cyc(12); check(speed_cmd, 16'h1194);
        press(6); cmp;
        press(1); wt(2, 0);
        i_tool.set_run(0); motor_stopped <= 1'b1; m_run = 0; cyc(30);
        press(6); m_loc = 1; cmp;
        i_tool.set_run(1); cyc(12); cmp;
        i_tool.set_run(0); cyc(8);
        $display("test run and mode done");
        for (j = 0; j < 6; j = j + 1) begin
            k = j ? j + 2 : 0;
            start_l;
            fault[k] <= 1'b1; m_run = 0; m_alm = 1 << k;
            wt(4, 0); motor_stopped <= 1'b1; cyc(6); cmp;
            check(alarm_lamp, 1);
            rd(0, d); check(d[7:0], m_alm);
            press(0); cmp;
            if (k != 4) begin clr(j % 2); cmp; end
            fault[k] <= 1'b0; cyc(8);
            clr(2); cmp;
            clr(j % 2); m_alm = 0; cmp;
        end
        $display("test latched alarms done");
        start_l;
        fault[2] <= 1'b1; wt(5, 1); wt(5, 0);
        fault[2] <= 1'b0; cyc(12); cmp;
        fault[2] <= 1'b1; m_run = 0; m_alm = 4;
        wt(4, 0); motor_stopped <= 1'b1; fault[2] <= 1'b0;
        cyc(6); cmp;
        clr(0); m_alm = 0; cmp;
        start_l;
        repeat (2) begin
            fault[1] <= 1'b1; cyc(10); fault[1] <= 1'b0; cyc(10);
        end
        cmp; rd(1, d); check(d[7:4], 2);
        fault[1] <= 1'b1; m_run = 0; m_alm = 2;
        wt(4, 0); motor_stopped <= 1'b1; fault[1] <= 1'b0;
        cyc(8); cmp;
        clr(1); m_alm = 0; cmp;
        $display("test voltage faults done");
        wrap_up;
    end
endmodule // prc_panel_alarm_bench

// ### prc_panel_alarm_monitor.sv
// Purpose: port checks of the pump run/alarm supervisor
// Assumes: bound to prc_panel_alarm, single clock domain
// Notes: checks wait out the internal reset lag
`timescale 1ns/100ps
module prc_mon (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // inputs watched
    input wire run_contact,
    input wire btn_run,
    input wire btn_stop,
    // outputs watched
    input wire run_status_contact,
    input wire alarm_status_contact,
    input wire drive_enable,
    input wire [15:0] speed_cmd,
    input wire run_lamp,
    input wire mode_lamp
);
    reg [2:0] up;
    wire ok;
    // outputs are forced low until a few edges after release
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    assign ok = (up == 3'h7);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_run_drive;
        ok && run_status_contact |-> drive_enable && run_lamp;
    endproperty
    a_run_drive: assert property (p_run_drive)
        else $error("run status without drive");
    property p_idle_speed;
        ok && !drive_enable |-> speed_cmd == 16'h0;
    endproperty
    a_idle_speed: assert property (p_idle_speed)
        else $error("speed command while idle");
    property p_alarm_no_run;
        (ok && !alarm_status_contact)[*3] |-> !run_status_contact;
    endproperty
    a_alarm_no_run: assert property (p_alarm_no_run)
        else $error("running while alarmed");
    property p_mode_hold;
        ok && run_lamp && $past(run_lamp) |-> $stable(mode_lamp);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed with run lamp on");
    property p_stop;
        ok && $rose(btn_stop) && run_status_contact
            |-> ##[1:10] !run_status_contact;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop button ignored");
    property p_remote_refuse;
        ok && !mode_lamp && !run_contact && !run_status_contact
            && $rose(btn_run) |-> !run_status_contact [*8];
    endproperty
    a_remote_refuse: assert property (p_remote_refuse)
        else $error("run button accepted in remote");
    property p_local_refuse;
        ok && mode_lamp && $rose(run_contact) && !run_status_contact
            |-> !run_status_contact [*8];
    endproperty
    a_local_refuse: assert property (p_local_refuse)
        else $error("run contact accepted in local");
    property p_decel_blink;
        ok && $rose(run_lamp) && !run_status_contact |-> ##[1:6] !run_lamp;
    endproperty
    a_decel_blink: assert property (p_decel_blink)
        else $error("run lamp not blinking");
    c_run: cover property (ok && $rose(run_status_contact));
    c_alarm: cover property (ok && $fell(alarm_status_contact));
    c_decel: cover property (ok && $rose(run_lamp) && !run_status_contact);
endmodule // prc_mon

bind prc_panel_alarm prc_mon i_mon (
    .mclk(mclk), .reset_n(reset_n), .run_contact(run_contact),
    .btn_run(btn_run), .btn_stop(btn_stop),
    .run_status_contact(run_status_contact),
    .alarm_status_contact(alarm_status_contact),
    .drive_enable(drive_enable), .speed_cmd(speed_cmd),
    .run_lamp(run_lamp), .mode_lamp(mode_lamp)
);

// ### prc_remote_tool.sv
// Purpose: remote equipment controller on the contact connector
// Assumes: contacts change just after a rising edge
// Notes: closures are held in whole clock cycles
`timescale 1ns/100ps
module prc_tool (
    // clock
    input wire mclk,
    // contacts towards the pump
    output reg run_contact,
    output reg alarm_reset_contact,
    output reg speed_mode_contact,
    output reg [9:0] speed_voltage
);
    initial begin
        run_contact = 1'b0;
        alarm_reset_contact = 1'b0;
        speed_mode_contact = 1'b0;
        speed_voltage = 10'h0;
    end
    // short holds let the bench show that brief closures are ignored
    task reset_pulse(input integer n);
        begin
            @(posedge mclk);
            alarm_reset_contact <= 1'b1;
            repeat (n) @(posedge mclk);
            alarm_reset_contact <= 1'b0;
        end
    endtask
    task set_run(input reg v);
        begin
            @(posedge mclk);
            run_contact <= v;
        end
    endtask
    task set_speed(input reg m, input reg [9:0] v);
        begin
            @(posedge mclk);
            speed_mode_contact <= m;
            speed_voltage <= v;
        end
    endtask
endmodule // prc_tool
